// *** hw/ispsq_pkg.sv ***
// shared constants for the in-system programming sequencer link
// What this block does
// R1: device floats all user pins during programming
// R2: all traffic via four-wire port, host clocks
// R3: host shifts opcode, address, data in serially
// R4: device shifts read data out, host compares
// R5: full run: enter, ID, erase, program, verify, exit
// R6: verify-only run skips erase and program
// R7: entry moves pins to programming, wait 1 ms
// R8: host checks silicon ID before other work
// R9: erase: shift command, then 100 ms pulse
// R10: per address: shift address, data, program pulse
// R11: per address: shift address, read pulse, shift out
// R12: exit returns pins to user mode, wait 1 ms
// R13: full program: 11.79 s pulses plus shifting
// R14: verify-only: 0.15 s pulses plus shifting
// R15: adaptive or constant algorithm may be used
// R16: host times waits on own clock, flags mismatch
package ispsq_pkg;
   // frame layout, first bit shifted is bit 0
   localparam int OP_W     = 8;
   localparam int ADDR_W   = 16;
   localparam int DATA_W   = 16;
   localparam int FRAME_W  = OP_W + ADDR_W + DATA_W;
   localparam int OP_LSB   = 0;
   localparam int ADDR_LSB = OP_W;
   localparam int DATA_LSB = OP_W + ADDR_W;
   localparam int BITCNT_W = 6;
   // cell array and user pins
   localparam int MEM_DEPTH = 64;
   localparam int MEM_AW    = 6;
   localparam int IO_W      = 8;
   // commands
   localparam logic [OP_W-1:0] OP_NOP    = 8'h00;
   localparam logic [OP_W-1:0] OP_ENTER  = 8'hA1;
   localparam logic [OP_W-1:0] OP_IDREAD = 8'h1D;
   localparam logic [OP_W-1:0] OP_ERASE  = 8'hE5;
   localparam logic [OP_W-1:0] OP_PROG   = 8'h7C;
   localparam logic [OP_W-1:0] OP_READ   = 8'h3B;
   localparam logic [OP_W-1:0] OP_EXIT   = 8'h5F;
   // silicon identifier, value arbitrary
   localparam logic [DATA_W-1:0] SILICON_ID  = 16'h5A3C;
   localparam logic [DATA_W-1:0] ERASED_WORD = 16'hFFFF;
   // host clock and test clock divider
   localparam int CLK_MHZ      = 200;
   localparam int TCK_HALF_CYC = 16;
   localparam int DIV_W        = 5;
   // waits and pulses in microseconds, and in host cycles
   localparam int STAGE_WAIT_US  = 1000;
   localparam int ERASE_PULSE_US = 100000;
   localparam int PROG_PULSE_US  = 100;
   localparam int READ_PULSE_US  = 1;
   localparam int STAGE_WAIT_CYC  = STAGE_WAIT_US * CLK_MHZ;
   localparam int ERASE_PULSE_CYC = ERASE_PULSE_US * CLK_MHZ;
   localparam int PROG_PULSE_CYC  = PROG_PULSE_US * CLK_MHZ;
   localparam int READ_PULSE_CYC  = READ_PULSE_US * CLK_MHZ;
   localparam int WAIT_W          = 32;
   // whole-part budget figures for the smallest part
   localparam int PROGRAM_PULSE_TOTAL_TIME_MS = 11790;    // R13
   localparam int PROGRAM_SHIFT_CYCLE_COUNT   = 2966000;  // R13
   localparam int VERIFY_PULSE_TOTAL_TIME_MS  = 150;      // R14
   localparam int VERIFY_SHIFT_CYCLE_COUNT    = 1806000;  // R14

   // builds one frame from its three fields
   function automatic logic [FRAME_W-1:0] frame_pack(input logic [OP_W-1:0]   op,
                                                     input logic [ADDR_W-1:0] addr,
                                                     input logic [DATA_W-1:0] data);
      frame_pack = {data, addr, op};
   endfunction
endpackage

// *** hw/ispsq_link_if.sv ***
// four-wire test port between programming host and device
`timescale 1ns/1ps
interface ispsq_link_if;
   logic tck;   // test clock, made by host
   logic tms;   // frame select, high while shifting
   logic tdi;   // serial data into device
   logic tdo;   // serial data out of device

   modport dev  (input tck, input tms, input tdi, output tdo);
   modport host (output tck, output tms, output tdi, input tdo);
endinterface

// *** hw/ispsq_device.sv ***
// device end: serial command decoder, cell array, pin float
`timescale 1ns/1ps
module ispsq_device (
   input  wire logic                        NRST_I,      // async reset, active low
   input  wire logic [ispsq_pkg::IO_W-1:0]  USER_OE_I,   // user logic pin enables
   output logic      [ispsq_pkg::IO_W-1:0]  PIN_OE_O,    // enables reaching the pins
   output logic                             ISP_MODE_O,  // programming mode active
   ispsq_link_if.dev                        link         // test port
);
   logic [ispsq_pkg::FRAME_W-1:0]  sr_q, sr_d;
   logic [ispsq_pkg::BITCNT_W-1:0] cnt_q, cnt_d;
   logic [ispsq_pkg::DATA_W-1:0]   out_q, out_d;
   logic                           in_system_programming_mode_q;
   logic                           in_system_programming_mode_d;
   logic [ispsq_pkg::DATA_W-1:0]   mem_q [ispsq_pkg::MEM_DEPTH];
   logic [ispsq_pkg::DATA_W-1:0]   mem_d [ispsq_pkg::MEM_DEPTH];
   logic [ispsq_pkg::FRAME_W-1:0]  word;
   logic [ispsq_pkg::OP_W-1:0]     op;
   logic [ispsq_pkg::MEM_AW-1:0]   idx;
   logic [ispsq_pkg::DATA_W-1:0]   wdata;

   // shift on every rising test clock edge with tms high, act on the last bit
   always_comb begin
      sr_d  = sr_q;
      cnt_d = cnt_q;
      out_d = out_q;
      in_system_programming_mode_d = in_system_programming_mode_q;
      mem_d = mem_q;
      word  = {link.tdi, sr_q[ispsq_pkg::FRAME_W-1:1]};            // R3
      op    = word[ispsq_pkg::OP_LSB +: ispsq_pkg::OP_W];
      idx   = word[ispsq_pkg::ADDR_LSB +: ispsq_pkg::MEM_AW];
      wdata = word[ispsq_pkg::DATA_LSB +: ispsq_pkg::DATA_W];
      if (link.tms) begin                                            // R2
         sr_d  = word;
         out_d = out_q >> 1;                                         // R4
         if (cnt_q == ispsq_pkg::BITCNT_W'(ispsq_pkg::FRAME_W - 1)) begin
            cnt_d = '0;
            case (op)
               ispsq_pkg::OP_ENTER: begin
                  in_system_programming_mode_d = 1'b1;               // R7
               end
               ispsq_pkg::OP_EXIT: begin
                  in_system_programming_mode_d = 1'b0;               // R12
               end
               ispsq_pkg::OP_IDREAD: begin
                  if (in_system_programming_mode_q) begin
                     out_d = ispsq_pkg::SILICON_ID;                  // R8
                  end
               end
               ispsq_pkg::OP_ERASE: begin
                  if (in_system_programming_mode_q) begin
                     for (int i = 0; i < ispsq_pkg::MEM_DEPTH; i++) begin
                        mem_d[i] = ispsq_pkg::ERASED_WORD;           // R9
                     end
                  end
               end
               ispsq_pkg::OP_PROG: begin
                  if (in_system_programming_mode_q) begin
                     mem_d[idx] = wdata;                             // R10
                  end
               end
               ispsq_pkg::OP_READ: begin
                  if (in_system_programming_mode_q) begin
                     out_d = mem_q[idx];                             // R11
                  end
               end
               default: begin
               end
            endcase
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end else begin
         cnt_d = '0;
      end
   end

   // registers on the link clock
   always_ff @(posedge link.tck or negedge NRST_I) begin
      if (!NRST_I) begin
         sr_q  <= '0;
         cnt_q <= '0;
         out_q <= '0;
         in_system_programming_mode_q <= 1'b0;
         for (int i = 0; i < ispsq_pkg::MEM_DEPTH; i++) begin
            mem_q[i] <= ispsq_pkg::ERASED_WORD;
         end
      end else begin
         sr_q  <= sr_d;
         cnt_q <= cnt_d;
         out_q <= out_d;
         in_system_programming_mode_q <= in_system_programming_mode_d;
         mem_q <= mem_d;
      end
   end

   // read-back bit and pin float
   assign link.tdo   = out_q[0];                                     // R4
   assign ISP_MODE_O = in_system_programming_mode_q;
   assign PIN_OE_O   = in_system_programming_mode_q ? '0 : USER_OE_I; // R1
endmodule

// *** hw/ispsq_host.sv ***
// host end: stage sequencer, timers and test clock shifter
`timescale 1ns/1ps
module ispsq_host #(
   parameter int unsigned STAGE_WAIT_CYC  = ispsq_pkg::STAGE_WAIT_CYC,
   parameter int unsigned ERASE_PULSE_CYC = ispsq_pkg::ERASE_PULSE_CYC,
   parameter int unsigned PROG_PULSE_CYC  = ispsq_pkg::PROG_PULSE_CYC
) (
   input  wire logic                          CLOCK_I,        // 200 MHz clock
   input  wire logic                          NRST_I,         // async reset, active low
   input  wire logic                          START_I,        // pulse: begin a run
   input  wire logic                          VERIFY_ONLY_I,  // run verify-only pass
   input  wire logic [ispsq_pkg::DATA_W-1:0]  IMG_DATA_I,     // image word at IMG_ADDR_O
   output logic      [ispsq_pkg::ADDR_W-1:0]  IMG_ADDR_O,     // image address wanted
   output logic                               BUSY_O,         // run in progress
   output logic                               DONE_O,         // run finished
   output logic                               ERROR_O,        // ID or verify mismatch
   ispsq_link_if.host                         link            // test port
);
   typedef enum {
      S_IDLE, S_ENTER, S_ID, S_IDCHK, S_ERASE, S_PROG, S_VER, S_VCHK, S_EXIT
   } ispsq_state_t;
   typedef enum {PH_ISSUE, PH_SHIFT, PH_WAIT} ispsq_phase_t;

   // shifter state
   logic [ispsq_pkg::DIV_W-1:0]    div_q, div_d;
   logic                           tck_q, tck_d;
   logic                           tms_q, tms_d;
   logic                           tdi_q, tdi_d;
   logic                           busy_q, busy_d;
   logic [ispsq_pkg::BITCNT_W-1:0] bits_q, bits_d;
   logic [ispsq_pkg::FRAME_W-1:0]  frame_q, frame_d;
   logic [ispsq_pkg::DATA_W-1:0]   rx_q, rx_d;
   logic                           tdo_s1_q, tdo_s2_q;
   logic                           tick;
   logic                           sh_done;
   logic                           sh_start;
   logic [ispsq_pkg::FRAME_W-1:0]  sh_frame;
   // sequencer state
   ispsq_state_t                   st_q, st_d;
   ispsq_phase_t                   ph_q, ph_d;
   logic [ispsq_pkg::WAIT_W-1:0]   wait_q, wait_d;
   logic [ispsq_pkg::ADDR_W-1:0]   addr_q, addr_d;
   logic                           err_q, err_d;
   logic                           done_q, done_d;
   logic                           vonly_q, vonly_d;
   logic                           last_addr;

   // two-flop synchroniser on the returning data pin
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tdo_s1_q <= 1'b0;
         tdo_s2_q <= 1'b0;
      end else begin
         tdo_s1_q <= link.tdo;
         tdo_s2_q <= tdo_s1_q;
      end
   end

   // test clock divider and one-frame serial shifter
   assign tick    = (div_q == ispsq_pkg::DIV_W'(ispsq_pkg::TCK_HALF_CYC - 1));
   assign sh_done = busy_q & tick & tck_q &
                    (bits_q == ispsq_pkg::BITCNT_W'(ispsq_pkg::FRAME_W));

   always_comb begin
      div_d   = div_q;
      tck_d   = tck_q;
      tms_d   = tms_q;
      tdi_d   = tdi_q;
      busy_d  = busy_q;
      bits_d  = bits_q;
      frame_d = frame_q;
      rx_d    = rx_q;
      if (!busy_q) begin
         div_d = '0;
         if (sh_start) begin
            busy_d  = 1'b1;
            tms_d   = 1'b1;
            tdi_d   = sh_frame[0];                                   // R3
            frame_d = sh_frame >> 1;
            bits_d  = '0;
         end
      end else begin
         div_d = tick ? '0 : div_q + 1'b1;
         if (tick && !tck_q) begin
            tck_d = 1'b1;                                            // R2
            if (bits_q < ispsq_pkg::BITCNT_W'(ispsq_pkg::DATA_W)) begin
               rx_d = {tdo_s2_q, rx_q[ispsq_pkg::DATA_W-1:1]};       // R4
            end
            bits_d = bits_q + 1'b1;
         end else if (tick) begin
            tck_d = 1'b0;
            if (sh_done) begin
               busy_d = 1'b0;
               tms_d  = 1'b0;
               tdi_d  = 1'b0;
            end else begin
               tdi_d   = frame_q[0];
               frame_d = frame_q >> 1;
            end
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         div_q   <= '0;
         tck_q   <= 1'b0;
         tms_q   <= 1'b0;
         tdi_q   <= 1'b0;
         busy_q  <= 1'b0;
         bits_q  <= '0;
         frame_q <= '0;
         rx_q    <= '0;
      end else begin
         div_q   <= div_d;
         tck_q   <= tck_d;
         tms_q   <= tms_d;
         tdi_q   <= tdi_d;
         busy_q  <= busy_d;
         bits_q  <= bits_d;
         frame_q <= frame_d;
         rx_q    <= rx_d;
      end
   end

   // stage sequencer: issue frame, wait for shift, then time the pulse
   assign last_addr = (addr_q == ispsq_pkg::ADDR_W'(ispsq_pkg::MEM_DEPTH - 1));

   always_comb begin
      st_d     = st_q;
      ph_d     = ph_q;
      wait_d   = wait_q;
      addr_d   = addr_q;
      err_d    = err_q;
      done_d   = done_q;
      vonly_d  = vonly_q;
      sh_start = 1'b0;
      case (st_q)
         S_ENTER: sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_ENTER, '0, '0);
         S_ID:    sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_IDREAD, '0, '0);
         S_ERASE: sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_ERASE, '0, '0);
         S_PROG:  sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_PROG, addr_q, IMG_DATA_I); // R10
         S_VER:   sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_READ, addr_q, '0);  // R11
         S_EXIT:  sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_EXIT, '0, '0);
         default: sh_frame = ispsq_pkg::frame_pack(ispsq_pkg::OP_NOP, '0, '0);
      endcase
      if (st_q == S_IDLE) begin
         if (START_I) begin
            st_d    = S_ENTER;                                       // R5
            ph_d    = PH_ISSUE;
            addr_d  = '0;
            err_d   = 1'b0;
            done_d  = 1'b0;
            vonly_d = VERIFY_ONLY_I;
         end
      end else begin
         case (ph_q)
            PH_ISSUE: begin
               sh_start = 1'b1;
               ph_d     = PH_SHIFT;
            end
            PH_SHIFT: begin
               if (sh_done) begin
                  ph_d = PH_WAIT;
                  case (st_q)                                        // R16
                     S_ENTER: wait_d = STAGE_WAIT_CYC;               // R7
                     S_ERASE: wait_d = ERASE_PULSE_CYC;              // R9
                     S_PROG:  wait_d = PROG_PULSE_CYC;               // R10
                     S_VER:   wait_d = ispsq_pkg::READ_PULSE_CYC;    // R11
                     S_EXIT:  wait_d = STAGE_WAIT_CYC;               // R12
                     default: wait_d = '0;
                  endcase
               end
            end
            PH_WAIT: begin
               if (wait_q != '0) begin
                  wait_d = wait_q - 1'b1;
               end else begin
                  ph_d = PH_ISSUE;
                  case (st_q)
                     S_ENTER: st_d = S_ID;                           // R8
                     S_ID:    st_d = S_IDCHK;
                     S_IDCHK: begin
                        if (rx_q != ispsq_pkg::SILICON_ID) begin
                           err_d = 1'b1;                             // R16
                           st_d  = S_EXIT;
                        end else begin
                           st_d = vonly_q ? S_VER : S_ERASE;         // R6
                        end
                     end
                     S_ERASE: st_d = S_PROG;
                     S_PROG: begin                                   // R15
                        addr_d = last_addr ? '0 : addr_q + 1'b1;
                        st_d   = last_addr ? S_VER : S_PROG;
                     end
                     S_VER:   st_d = S_VCHK;
                     S_VCHK: begin
                        if (rx_q != IMG_DATA_I) begin
                           err_d = 1'b1;                             // R4
                           st_d  = S_EXIT;
                        end else begin
                           addr_d = last_addr ? addr_q : addr_q + 1'b1;
                           st_d   = last_addr ? S_EXIT : S_VER;
                        end
                     end
                     S_EXIT: begin
                        st_d   = S_IDLE;
                        done_d = 1'b1;
                     end
                     default: st_d = S_IDLE;
                  endcase
               end
            end
            default: ph_d = PH_ISSUE;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         st_q    <= S_IDLE;
         ph_q    <= PH_ISSUE;
         wait_q  <= '0;
         addr_q  <= '0;
         err_q   <= 1'b0;
         done_q  <= 1'b0;
         vonly_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         ph_q    <= ph_d;
         wait_q  <= wait_d;
         addr_q  <= addr_d;
         err_q   <= err_d;
         done_q  <= done_d;
         vonly_q <= vonly_d;
      end
   end

   // outputs
   assign link.tck   = tck_q;
   assign link.tms   = tms_q;
   assign link.tdi   = tdi_q;
   assign IMG_ADDR_O = addr_q;
   assign BUSY_O     = (st_q != S_IDLE);
   assign DONE_O     = done_q;
   assign ERROR_O    = err_q;
endmodule

// *** tb/ispsq_link_asserts.sv ***
// concurrent checks on the test port and the pin float
`timescale 1ns/1ps
module ispsq_link_asserts (
   input wire logic                       CLOCK_I,    // host clock
   input wire logic                       NRST_I,     // host reset, active low
   input wire logic                       START_I,    // run request
   input wire logic                       BUSY_O,     // run in progress
   input wire logic                       DONE_O,     // run finished
   input wire logic                       ERROR_O,    // mismatch flag
   input wire logic [ispsq_pkg::IO_W-1:0] USER_OE_I,  // user enables
   input wire logic [ispsq_pkg::IO_W-1:0] PIN_OE_O,   // pin enables
   input wire logic                       ISP_MODE_O, // programming mode
   input wire logic                       tck,        // test clock
   input wire logic                       tms,        // frame select
   input wire logic                       tdi,        // data to device
   input wire logic                       tdo         // data from device
);
   logic       tck_q;
   logic       tck_d;
   logic [5:0] rise_q;
   logic [5:0] rise_d;

   // count test clock rises inside one frame
   always_comb begin
      tck_d  = tck;
      rise_d = rise_q;
      if (!tms) begin
         rise_d = 6'h00;
      end else if (tck && !tck_q) begin
         rise_d = rise_q + 6'h01;
      end
   end

   // helper registers
   always_ff @(posedge CLOCK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         tck_q  <= 1'b0;
         rise_q <= 6'h00;
      end else begin
         tck_q  <= tck_d;
         rise_q <= rise_d;
      end
   end

   // pin enables, link wire shape, mode changes and run start
   pin_float_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      PIN_OE_O == (ISP_MODE_O ? 8'h00 : USER_OE_I)) else $error("pin enables wrong");
   tck_idle_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      !tms |-> !tck) else $error("test clock runs outside frame");
   tck_period_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      $rose(tck) |-> ##16 $fell(tck)) else $error("test clock half period wrong");
   tdi_stable_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      tck |-> $stable(tdi)) else $error("data in moved while clock high");
   frame_len_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      $fell(tms) |-> rise_q == 6'h28) else $error("frame length wrong");
   tdo_shift_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      $changed(tdo) |-> $rose(tck)) else $error("data out moved off rising edge");
   isp_enter_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      $rose(ISP_MODE_O) |-> $rose(tck) && tms && rise_q == 6'h27)
      else $error("mode entered off last frame edge");
   isp_exit_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      $fell(ISP_MODE_O) |-> $rose(tck) && tms && rise_q == 6'h27)
      else $error("mode left off last frame edge");
   start_clear_a: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
      START_I && !BUSY_O |=> BUSY_O && !DONE_O && !ERROR_O) else $error("start not taken");
endmodule

// *** tb/tb_isp_program_sequencer.sv ***
// self-checking bench: host and device joined over the test port
`timescale 1ns/1ps
// count a comparison, report a mismatch
`define CHECK(got, exp, msg) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("[FAIL] t=%0t %s", $time, msg); \
      end \
   end
module tb_isp_program_sequencer;
   typedef struct packed {
      logic [39:0] frame;
      logic [39:0] mask;
      logic        rchk;
      logic [15:0] rdata;
   } ispsq_exp_t;
   localparam logic [39:0] M_OP = 40'h00000000FF;
   localparam logic [39:0] M_RD = 40'h0000FFFFFF;
   logic        clk;
   logic        nrst_host;
   logic        nrst_dev;
   logic        start;
   logic        vonly;
   logic        busy;
   logic        done;
   logic        error;
   logic        isp_mode;
   logic [7:0]  user_oe;
   logic [7:0]  pin_oe;
   logic [15:0] img_data;
   logic [15:0] img_addr;
   logic [15:0] img [64];
   logic [39:0] fbits;
   logic [39:0] rbits;
   ispsq_exp_t  exp_q [$];
   ispsq_exp_t  e;
   int          nbit = 0;
   int          nframes = 0;
   int          n_mismatch = 0;
   int          cmp_count = 0;

   ispsq_link_if ispsq_link_if_i ();
   ispsq_host #(.STAGE_WAIT_CYC(20), .ERASE_PULSE_CYC(50), .PROG_PULSE_CYC(300)) ispsq_host_i (
      .CLOCK_I       (clk),
      .NRST_I        (nrst_host),
      .START_I       (start),
      .VERIFY_ONLY_I (vonly),
      .IMG_DATA_I    (img_data),
      .IMG_ADDR_O    (img_addr),
      .BUSY_O        (busy),
      .DONE_O        (done),
      .ERROR_O       (error),
      .link          (ispsq_link_if_i)
   );
   ispsq_device ispsq_device_i (
      .NRST_I     (nrst_dev),
      .USER_OE_I  (user_oe),
      .PIN_OE_O   (pin_oe),
      .ISP_MODE_O (isp_mode),
      .link       (ispsq_link_if_i)
   );
   ispsq_link_asserts ispsq_link_asserts_i (
      .CLOCK_I    (clk),
      .NRST_I     (nrst_host),
      .START_I    (start),
      .BUSY_O     (busy),
      .DONE_O     (done),
      .ERROR_O    (error),
      .USER_OE_I  (user_oe),
      .PIN_OE_O   (pin_oe),
      .ISP_MODE_O (isp_mode),
      .tck        (ispsq_link_if_i.tck),
      .tms        (ispsq_link_if_i.tms),
      .tdi        (ispsq_link_if_i.tdi),
      .tdo        (ispsq_link_if_i.tdo)
   );
   assign img_data = img[img_addr[5:0]];

   // 200 MHz host clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // decode each frame on the wire, compare with the oldest note
   always @(posedge ispsq_link_if_i.tck) begin
      if (!ispsq_link_if_i.tms) begin
         nbit = 0;
      end else begin
         fbits[nbit] = ispsq_link_if_i.tdi;
         rbits[nbit] = ispsq_link_if_i.tdo;
         nbit++;
         if (nbit == 40) begin
            nbit = 0;
            nframes++;
            if (exp_q.size() == 0) begin
               `CHECK(1'b1, 1'b0, "unexpected frame")
            end else begin
               e = exp_q.pop_front();
               `CHECK(fbits & e.mask, e.frame & e.mask, "frame content")
               if (e.rchk) `CHECK(rbits[15:0], e.rdata, "read back word")
            end
         end
      end
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic step();
      @(negedge clk);
      user_oe <= 8'($urandom);
   endtask

   task automatic note(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
                       input logic [39:0] m, input logic rc, input logic [15:0] r);
      exp_q.push_back({d, a, op, m, rc, r});
   endtask

   task automatic note_op(input logic [7:0] op, input logic rc, input logic [15:0] r);
      note(op, 16'h0000, 16'h0000, M_OP, rc, r);
   endtask

   task automatic note_open();
      note_op(ispsq_pkg::OP_ENTER, 1'b0, 16'h0000);
      note_op(ispsq_pkg::OP_IDREAD, 1'b0, 16'h0000);
      note_op(ispsq_pkg::OP_NOP, 1'b1, ispsq_pkg::SILICON_ID);
   endtask

   task automatic note_verify(input int a, input logic [15:0] r);
      note(ispsq_pkg::OP_READ, 16'(a), 16'h0000, M_RD, 1'b0, 16'h0000);
      note_op(ispsq_pkg::OP_NOP, 1'b1, r);
   endtask

   task automatic start_run(input logic v);
      @(negedge clk);
      start = 1'b1;
      vonly = v;
      step();
      start = 1'b0;
      `CHECK({busy, done, error}, 3'b100, "run not started")
   endtask

   task automatic wait_until(input logic on_done, input int n, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         if (on_done ? done === 1'b1 : nframes >= n) break;
         step();
      end
      if (i == lim) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask

   // main sequence
   initial begin
      void'($urandom(32'hC592C748));
      {nrst_host, nrst_dev, start, vonly, user_oe} = '0;
      for (int i = 0; i < 64; i++) img[i] = 16'($urandom) & 16'h7FFF;
      repeat (12) step();
      {nrst_host, nrst_dev} = 2'b11;
      // full run, host reset during the program stage
      note_open();
      note_op(ispsq_pkg::OP_ERASE, 1'b0, 16'h0000);
      for (int a = 0; a < 4; a++) note(ispsq_pkg::OP_PROG, 16'(a), img[a], '1, 1'b0, 16'h0);
      start_run(1'b0);
      wait_until(1'b0, 8, 20000);
      repeat (60) step();
      `CHECK(pin_oe, 8'h00, "pins not floated")
      nrst_host = 1'b0;
      repeat (12) step();
      nrst_host = 1'b1;
      `CHECK({busy, done, isp_mode}, 3'b001, "state after host reset")
      $display("test program_then_reset done");
      // verify-only run, stops at first unwritten word, second start refused
      note_open();
      for (int a = 0; a < 4; a++) note_verify(a, img[a]);
      note_verify(4, ispsq_pkg::ERASED_WORD);
      note_op(ispsq_pkg::OP_EXIT, 1'b0, 16'h0000);
      start_run(1'b1);
      repeat (100) step();
      {start, vonly} = 2'b10;
      step();
      start = 1'b0;
      wait_until(1'b1, 0, 40000);
      `CHECK({done, error, isp_mode}, 3'b110, "verify outcome")
      `CHECK(pin_oe, user_oe, "pins not returned")
      `CHECK(exp_q.size(), 0, "frames missing")
      $display("test verify_only done");
      // back-to-back run, mismatch on the first word
      img[0] = img[0] ^ 16'h0001;
      note_open();
      note_verify(0, img[0] ^ 16'h0001);
      note_op(ispsq_pkg::OP_EXIT, 1'b0, 16'h0000);
      start_run(1'b1);
      wait_until(1'b1, 0, 20000);
      `CHECK({done, error, isp_mode}, 3'b110, "first word outcome")
      `CHECK(exp_q.size(), 0, "frames missing")
      $display("test first_word_mismatch done");
      report_and_stop();
   end
endmodule
